// >>> design/bes_params.svh
// Constants of the brake and emergency-stop sequencer: indices, resets, timing.
// Assumes it is included by bare name from the package and the design module.
`ifndef BES_PARAMS_SVH
`define BES_PARAMS_SVH
`define BES_DW              16
`define BES_IDX_POFF_DELAY  16'h2437
`define BES_IDX_REL_DELAY   16'h2438
`define BES_IDX_ESTOP_SEL   16'h2443
`define BES_IDX_INHIBIT_CFG 16'h2504
`define BES_IDX_BRAKE_TQ    16'h2511
`define BES_RST_POFF_DELAY  16'h0064
`define BES_RST_REL_DELAY   16'h0000
`define BES_RST_ESTOP_SEL   16'h0000
`define BES_RST_INHIBIT_CFG 16'h0000
`define BES_RST_BRAKE_TQ    16'h0000
`define BES_ESTOP_VALID     16'h0000
`define BES_INH_DIRECTIONAL 16'h0000
`define BES_INH_SINGLE_ALM  16'h0002
`define BES_ZERO            16'h0000
`define BES_MS_ONE          16'h0001
`define BES_TICK_PERIOD_NS  1000000
`define BES_CLK_PERIOD_NS   5
`define BES_TICK_W          18
`define BES_TICK_ONE        18'h00001
`define BES_TICK_ZERO       18'h00000
`endif

// >>> design/bes_pkg.sv
// Types of the brake and emergency-stop sequencer: state codes and the state record.
// Assumes bes_params.svh is on the include path.
`include "bes_params.svh"
package bes_pkg;
  // One-hot sequencer states.
  typedef enum logic [4:0] {
    BES_OFF     = 5'h01,
    BES_RELEASE = 5'h02,
    BES_RUN     = 5'h04,
    BES_DECEL   = 5'h08,
    BES_HOLD    = 5'h10
  } bes_state_t;

  // Whole state of the sequencer in one record.
  typedef struct packed {
    bes_state_t                 state;
    logic [`BES_TICK_W-1:0]     tick_cnt;
    logic                       tick;
    logic [`BES_DW-1:0]         ms_cnt;
    logic [`BES_DW-1:0]         poff_delay;
    logic [`BES_DW-1:0]         rel_delay;
    logic [`BES_DW-1:0]         estop_sel;
    logic [`BES_DW-1:0]         inhibit_cfg;
    logic [`BES_DW-1:0]         brake_tq;
    logic [`BES_DW-1:0]         rdata;
    logic                       estop_alarm;
    logic                       inhibit_alarm;
    logic                       pos_block;
    logic                       neg_block;
    logic [`BES_DW-1:0]         torque_limit;
  } bes_state_rec_t;
endpackage : bes_pkg

// >>> design/bes_sequencer.sv
// Holding-brake, emergency-stop and travel-inhibit sequencer of a servo drive.
// Assumes all inputs are synchronous to CLK_SYS and parameters arrive by index writes.
//
// What this block does
// - Hold position, mask commands during release delay.
// - Brake release output on once enabled, timed.
// - Time power-off delay so axis cannot slide.
// - Decel ends on time limit or low speed.
// - Alarm or inhibit while enabled starts emergency stop.
// - Select 0 forces stop with alarm; 1 not.
// - Inhibit config 0 blocks direction; 1 ignores.
// - Config 2: single-sided inhibit raises travel alarm.
// - Homing with option bit ignores inhibit inputs.
// - Braking torque limit during braking; 0 normal.
// - Effective limit is smaller of both values.
`timescale 1ns/1ps
`include "bes_params.svh"
module bes_sequencer
  import bes_pkg::*;
#(
  parameter int TICK_CYCLES = `BES_TICK_PERIOD_NS / `BES_CLK_PERIOD_NS
)(
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic                CE,
  input  wire logic [`BES_DW-1:0]  OD_INDEX,
  input  wire logic [`BES_DW-1:0]  OD_WDATA,
  input  wire logic                OD_WR,
  input  wire logic                OD_RD,
  output logic      [`BES_DW-1:0]  OD_RDATA,
  input  wire logic                DRIVE_ENABLE,
  input  wire logic                ALARM_IN,
  input  wire logic                QUICK_STOP_REQ,
  input  wire logic                HOMING_ACTIVE,
  input  wire logic                HOMING_OPT_BIT0,
  input  wire logic                POSITIVE_TRAVEL_INHIBIT,
  input  wire logic                NEGATIVE_TRAVEL_INHIBIT,
  input  wire logic [`BES_DW-1:0]  MOTOR_SPEED,
  input  wire logic [`BES_DW-1:0]  BRAKE_SPEED_THRESHOLD,
  input  wire logic [`BES_DW-1:0]  STOP_DECEL_TIME_LIMIT,
  input  wire logic [`BES_DW-1:0]  MAX_TORQUE,
  output logic                     MOTOR_POWER,
  output logic                     BRAKE_RELEASE_OUTPUT,
  output logic                     BRAKE_ENGAGE_OUTPUT,
  output logic                     COMMAND_MASK,
  output logic                     STOP_ACTIVE,
  output logic                     ESTOP_ALARM,
  output logic                     TRAVEL_INHIBIT_ALARM,
  output logic                     POS_DRIVE_BLOCK,
  output logic                     NEG_DRIVE_BLOCK,
  output logic      [`BES_DW-1:0]  TORQUE_LIMIT
);

  // Tick period as a sized count; the last value of the prescaler.
  localparam logic [`BES_TICK_W-1:0] TICK_LAST = `BES_TICK_W'(TICK_CYCLES - 1);

  bes_state_rec_t s_reg;        // Registered state record.
  bes_state_rec_t s_next;       // Next value of the record.

  logic inhibit_used;           // Inhibit inputs count in this cycle.
  logic one_sided;              // Exactly one inhibit input is active.
  logic inhibit_trip;           // Inhibit condition that stops the drive.
  logic estop_trip;             // Emergency stop cause while enabled.
  logic force_stop;             // Stop that overrides the enable.
  logic stop_req;               // Any reason to leave motion.
  logic delay_done_rel;         // Release delay has elapsed.
  logic delay_done_poff;        // Power-off delay has elapsed.
  logic decel_done;             // Deceleration phase may end.
  logic [`BES_DW-1:0] brake_cap; // Torque cap while braking.

  // Cause decoding, kept apart from the record update for readability.
  always_comb
  begin
    // Inhibit inputs are ignored in homing when the master set the option bit.
    inhibit_used = !(HOMING_ACTIVE && HOMING_OPT_BIT0);
    one_sided    = POSITIVE_TRAVEL_INHIBIT ^ NEGATIVE_TRAVEL_INHIBIT;
    inhibit_trip = 1'b0;
    if (inhibit_used && (s_reg.inhibit_cfg == `BES_INH_SINGLE_ALM))
    begin
      inhibit_trip = one_sided;
    end
    // A directional inhibit also counts as a prohibition signal for the stop.
    else if (inhibit_used && (s_reg.inhibit_cfg == `BES_INH_DIRECTIONAL))
    begin
      inhibit_trip = POSITIVE_TRAVEL_INHIBIT || NEGATIVE_TRAVEL_INHIBIT;
    end
    // Only an enabled drive stops on alarm or prohibition.
    estop_trip = DRIVE_ENABLE && (ALARM_IN || inhibit_trip);
    // Quick stop from the master acts even when the select disables the stop.
    force_stop = (estop_trip && (s_reg.estop_sel == `BES_ESTOP_VALID))
                 || QUICK_STOP_REQ || s_reg.estop_alarm;
    stop_req   = !DRIVE_ENABLE || force_stop;
    // Delay compares happen only on the tick, so a new value acts on the next tick.
    delay_done_rel  = s_reg.tick && (s_reg.ms_cnt >= s_reg.rel_delay);
    delay_done_poff = s_reg.tick && (s_reg.ms_cnt >= s_reg.poff_delay);
    // Whichever comes first ends deceleration.
    decel_done = (MOTOR_SPEED < BRAKE_SPEED_THRESHOLD)
                 || (s_reg.tick && (s_reg.ms_cnt >= STOP_DECEL_TIME_LIMIT));
    // A zero braking setting keeps the normal limit.
    if (s_reg.brake_tq == `BES_ZERO)
    begin
      brake_cap = MAX_TORQUE;
    end
    else
    begin
      brake_cap = (s_reg.brake_tq < MAX_TORQUE) ? s_reg.brake_tq : MAX_TORQUE;
    end
  end

  // Next-state logic of the whole record.
  always_comb
  begin
    s_next = s_reg;
    // Free-running prescaler for the millisecond tick.
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == TICK_LAST)
    begin
      s_next.tick_cnt = `BES_TICK_ZERO;
      s_next.tick     = 1'b1;
    end
    else
    begin
      s_next.tick_cnt = s_reg.tick_cnt + `BES_TICK_ONE;
    end
    // Millisecond counter, saturating so a long wait never wraps.
    if (s_reg.tick && (s_reg.ms_cnt != {`BES_DW{1'b1}}))
    begin
      s_next.ms_cnt = s_reg.ms_cnt + `BES_MS_ONE;
    end

    // Parameter writes by object index; unknown indices are ignored.
    if (OD_WR)
    begin
      case (OD_INDEX)
        `BES_IDX_POFF_DELAY:  s_next.poff_delay  = OD_WDATA;
        `BES_IDX_REL_DELAY:   s_next.rel_delay   = OD_WDATA;
        `BES_IDX_ESTOP_SEL:   s_next.estop_sel   = OD_WDATA;
        `BES_IDX_INHIBIT_CFG: s_next.inhibit_cfg = OD_WDATA;
        `BES_IDX_BRAKE_TQ:    s_next.brake_tq    = OD_WDATA;
        default:              s_next.rdata       = s_reg.rdata;
      endcase
    end
    // Reads return the stored value one cycle later; unknown indices read zero.
    if (OD_RD)
    begin
      case (OD_INDEX)
        `BES_IDX_POFF_DELAY:  s_next.rdata = s_reg.poff_delay;
        `BES_IDX_REL_DELAY:   s_next.rdata = s_reg.rel_delay;
        `BES_IDX_ESTOP_SEL:   s_next.rdata = s_reg.estop_sel;
        `BES_IDX_INHIBIT_CFG: s_next.rdata = s_reg.inhibit_cfg;
        `BES_IDX_BRAKE_TQ:    s_next.rdata = s_reg.brake_tq;
        default:              s_next.rdata = `BES_ZERO;
      endcase
    end

    // Alarms latch; the set wins over the clear, which happens while disabled.
    if (!DRIVE_ENABLE)
    begin
      s_next.estop_alarm   = 1'b0;
      s_next.inhibit_alarm = 1'b0;
    end
    if (estop_trip && (s_reg.estop_sel == `BES_ESTOP_VALID))
    begin
      s_next.estop_alarm = 1'b1;
    end
    if (inhibit_used && (s_reg.inhibit_cfg == `BES_INH_SINGLE_ALM) && one_sided)
    begin
      s_next.inhibit_alarm = 1'b1;
    end

    // Directional blocking applies only in config 0; config 1 ignores inputs.
    s_next.pos_block = inhibit_used && (s_reg.inhibit_cfg == `BES_INH_DIRECTIONAL)
                       && POSITIVE_TRAVEL_INHIBIT;
    s_next.neg_block = inhibit_used && (s_reg.inhibit_cfg == `BES_INH_DIRECTIONAL)
                       && NEGATIVE_TRAVEL_INHIBIT;

    // Sequencer. Every state change restarts the millisecond counter.
    case (s_reg.state)
      BES_OFF:
      begin
        // A latched stop alarm keeps the drive off until it is disabled.
        if (DRIVE_ENABLE && !force_stop)
        begin
          s_next.state  = BES_RELEASE;
          s_next.ms_cnt = `BES_ZERO;
        end
      end
      BES_RELEASE:
      begin
        // Brake is being released; position is held and commands masked.
        if (stop_req)
        begin
          s_next.state  = BES_DECEL;
          s_next.ms_cnt = `BES_ZERO;
        end
        else if (delay_done_rel)
        begin
          s_next.state  = BES_RUN;
          s_next.ms_cnt = `BES_ZERO;
        end
      end
      BES_RUN:
      begin
        if (stop_req)
        begin
          s_next.state  = BES_DECEL;
          s_next.ms_cnt = `BES_ZERO;
        end
      end
      BES_DECEL:
      begin
        // The brake only changes after the deceleration phase has ended.
        if (decel_done)
        begin
          s_next.state  = BES_HOLD;
          s_next.ms_cnt = `BES_ZERO;
        end
      end
      BES_HOLD:
      begin
        // Motor keeps torque while the brake closes, so the axis cannot slide.
        if (delay_done_poff)
        begin
          s_next.state  = BES_OFF;
          s_next.ms_cnt = `BES_ZERO;
        end
      end
      default:
      begin
        s_next.state  = BES_OFF;
        s_next.ms_cnt = `BES_ZERO;
      end
    endcase

    // Braking limit while stopping, normal limit otherwise.
    s_next.torque_limit = (s_next.state == BES_DECEL) ? brake_cap : MAX_TORQUE;
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s_reg.state         <= BES_OFF;
      s_reg.tick_cnt      <= `BES_TICK_ZERO;
      s_reg.tick          <= 1'b0;
      s_reg.ms_cnt        <= `BES_ZERO;
      s_reg.poff_delay    <= `BES_RST_POFF_DELAY;
      s_reg.rel_delay     <= `BES_RST_REL_DELAY;
      s_reg.estop_sel     <= `BES_RST_ESTOP_SEL;
      s_reg.inhibit_cfg   <= `BES_RST_INHIBIT_CFG;
      s_reg.brake_tq      <= `BES_RST_BRAKE_TQ;
      s_reg.rdata         <= `BES_ZERO;
      s_reg.estop_alarm   <= 1'b0;
      s_reg.inhibit_alarm <= 1'b0;
      s_reg.pos_block     <= 1'b0;
      s_reg.neg_block     <= 1'b0;
      s_reg.torque_limit  <= `BES_ZERO;
    end
    else if (CE)
    begin
      s_reg <= s_next;
    end
  end

  // Outputs decode the registered state; the brake follows the state directly.
  assign MOTOR_POWER          = (s_reg.state != BES_OFF);
  assign BRAKE_RELEASE_OUTPUT = (s_reg.state == BES_RELEASE) || (s_reg.state == BES_RUN)
                                || (s_reg.state == BES_DECEL);
  assign BRAKE_ENGAGE_OUTPUT  = !BRAKE_RELEASE_OUTPUT;
  assign COMMAND_MASK         = (s_reg.state != BES_RUN);
  assign STOP_ACTIVE          = (s_reg.state == BES_DECEL);
  assign ESTOP_ALARM          = s_reg.estop_alarm;
  assign TRAVEL_INHIBIT_ALARM = s_reg.inhibit_alarm;
  assign POS_DRIVE_BLOCK      = s_reg.pos_block;
  assign NEG_DRIVE_BLOCK      = s_reg.neg_block;
  assign TORQUE_LIMIT         = s_reg.torque_limit;
  assign OD_RDATA             = s_reg.rdata;

endmodule : bes_sequencer

// >>> testbench/bes_sequencer_properties.sv
// Port checker for the brake and emergency-stop sequencer.
// Assumes CE stays high and the stop phase is set to a few ms.
`timescale 1ns/1ps
`include "bes_params.svh"
module bes_seq_chk
  import bes_pkg::*;
(
  input wire logic               CLK_SYS,
  input wire logic               RST,
  input wire logic               DRIVE_ENABLE,
  input wire logic               ALARM_IN,
  input wire logic               QUICK_STOP_REQ,
  input wire logic               POSITIVE_TRAVEL_INHIBIT,
  input wire logic               NEGATIVE_TRAVEL_INHIBIT,
  input wire logic [`BES_DW-1:0] MOTOR_SPEED,
  input wire logic [`BES_DW-1:0] BRAKE_SPEED_THRESHOLD,
  input wire logic [`BES_DW-1:0] MAX_TORQUE,
  input wire logic               MOTOR_POWER,
  input wire logic               BRAKE_RELEASE_OUTPUT,
  input wire logic               BRAKE_ENGAGE_OUTPUT,
  input wire logic               COMMAND_MASK,
  input wire logic               STOP_ACTIVE,
  input wire logic               ESTOP_ALARM,
  input wire logic               TRAVEL_INHIBIT_ALARM,
  input wire logic [`BES_DW-1:0] TORQUE_LIMIT
);
  // Longest stop phase in cycles; a hung stop phase would otherwise go unseen.
  localparam int MAX_DECEL = 200;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  brake_pair_a: assert property (BRAKE_ENGAGE_OUTPUT == !BRAKE_RELEASE_OUTPUT)
    else $error("brake outputs not complementary");
  release_power_a: assert property (BRAKE_RELEASE_OUTPUT |-> MOTOR_POWER)
    else $error("brake released without motor power");
  run_unmasked_a: assert property (!COMMAND_MASK |-> BRAKE_RELEASE_OUTPUT && !STOP_ACTIVE)
    else $error("commands pass while brake held");
  power_on_a: assert property (!MOTOR_POWER && !$past(DRIVE_ENABLE) && DRIVE_ENABLE
    && !ALARM_IN && !QUICK_STOP_REQ && !ESTOP_ALARM && !POSITIVE_TRAVEL_INHIBIT
    && !NEGATIVE_TRAVEL_INHIBIT |=> MOTOR_POWER && BRAKE_RELEASE_OUTPUT && COMMAND_MASK)
    else $error("enable did not start brake release");
  stop_disable_a: assert property (!COMMAND_MASK && !DRIVE_ENABLE |=> STOP_ACTIVE)
    else $error("disable did not start stop phase");
  stop_speed_a: assert property (STOP_ACTIVE && MOTOR_SPEED < BRAKE_SPEED_THRESHOLD
    |=> !STOP_ACTIVE && !BRAKE_RELEASE_OUTPUT && MOTOR_POWER)
    else $error("low speed did not end stop phase");
  stop_bound_a: assert property ($rose(STOP_ACTIVE) |-> ##[1:MAX_DECEL] !STOP_ACTIVE)
    else $error("stop phase too long");
  brake_torque_a: assert property (STOP_ACTIVE && $past(STOP_ACTIVE)
    |-> TORQUE_LIMIT <= MAX_TORQUE)
    else $error("braking torque above maximum");
  single_side_a: assert property ($rose(TRAVEL_INHIBIT_ALARM)
    |-> $past(POSITIVE_TRAVEL_INHIBIT) != $past(NEGATIVE_TRAVEL_INHIBIT))
    else $error("travel alarm without one-sided inhibit");
endmodule : bes_seq_chk
bind bes_sequencer bes_seq_chk u_chk (.CLK_SYS, .RST, .DRIVE_ENABLE, .ALARM_IN,
  .QUICK_STOP_REQ, .POSITIVE_TRAVEL_INHIBIT, .NEGATIVE_TRAVEL_INHIBIT, .MOTOR_SPEED,
  .BRAKE_SPEED_THRESHOLD, .MAX_TORQUE, .MOTOR_POWER, .BRAKE_RELEASE_OUTPUT,
  .BRAKE_ENGAGE_OUTPUT, .COMMAND_MASK, .STOP_ACTIVE, .ESTOP_ALARM,
  .TRAVEL_INHIBIT_ALARM, .TORQUE_LIMIT);

// >>> testbench/bes_motor_model.sv
// Motor speed model behind the sequencer outputs.
// Assumes the sequencer clock; STEP zero models a load that will not slow.
`timescale 1ns/1ps
module bes_motor_model (
  input  wire logic        CLK_SYS,
  input  wire logic        MOTOR_POWER,
  input  wire logic        COMMAND_MASK,
  input  wire logic        STOP_ACTIVE,
  input  wire logic [15:0] STEP,
  output logic      [15:0] SPEED
);
  // Speed rises once commands pass and falls by STEP while braking.
  always @(posedge CLK_SYS)
  begin
    if (!MOTOR_POWER)
      SPEED <= 16'h0000;
    else if (!COMMAND_MASK)
      SPEED <= 16'h0400;
    else if (STOP_ACTIVE)
      SPEED <= (SPEED > STEP) ? SPEED - STEP : 16'h0000;
  end
endmodule : bes_motor_model

// >>> testbench/brake_estop_sequencer_tb.sv
// Self-checking bench for the brake and emergency-stop sequencer.
// Assumes a 10-clock tick, so one ms is ten cycles.
`timescale 1ns/1ps
module brake_estop_sequencer_tb
  import bes_pkg::*;
;
  typedef struct { logic [15:0] i; logic w; logic [15:0] d, e; } bes_row_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b0, alm = 1'b0;
  logic qs = 1'b0, hom = 1'b0, hb = 1'b0, pti = 1'b0, nti = 1'b0;
  logic pwr, rel, eng, msk, stp, ealm, talm, pblk, nblk;
  logic [15:0] idx = 16'h0000, wd = 16'h0000, rdat, spd, tq;
  logic [15:0] thr = 16'h0010, dl = 16'h0003, mt = 16'h0020, st = 16'h0100;
  int errors = 0, comparisons = 0, n;
  // Selectors for the drive and wait helpers below.
  localparam int in_en = 0, in_alm = 1, in_qs = 2, in_hom = 3, in_hb = 4, in_pti = 5;
  localparam int in_nti = 6, out_msk = 0, out_stp = 1, out_pwr = 2;
  // Register rows: reset reads, write-backs and one unmapped index.
  bes_row_t rows [10] = '{'{16'h2437,0,0,16'h0064}, '{16'h2438,0,0,0}, '{16'h2443,0,0,0},
    '{16'h2504,0,0,0}, '{16'h2511,0,0,0}, '{16'h2437,1,2,2}, '{16'h2438,1,2,2},
    '{16'h2511,1,16'h0010,16'h0010}, '{16'h2443,1,1,1}, '{16'h2439,1,5,0}};
  always #2.5 clk = !clk;
  bes_sequencer #(.TICK_CYCLES(10)) dut (.CLK_SYS(clk), .RST(rst), .CE(1'b1),
    .OD_INDEX(idx), .OD_WDATA(wd), .OD_WR(wr), .OD_RD(rd), .OD_RDATA(rdat),
    .DRIVE_ENABLE(en), .ALARM_IN(alm), .QUICK_STOP_REQ(qs), .HOMING_ACTIVE(hom),
    .HOMING_OPT_BIT0(hb), .POSITIVE_TRAVEL_INHIBIT(pti), .NEGATIVE_TRAVEL_INHIBIT(nti),
    .MOTOR_SPEED(spd), .BRAKE_SPEED_THRESHOLD(thr), .STOP_DECEL_TIME_LIMIT(dl),
    .MAX_TORQUE(mt), .MOTOR_POWER(pwr), .BRAKE_RELEASE_OUTPUT(rel),
    .BRAKE_ENGAGE_OUTPUT(eng), .COMMAND_MASK(msk), .STOP_ACTIVE(stp), .ESTOP_ALARM(ealm),
    .TRAVEL_INHIBIT_ALARM(talm), .POS_DRIVE_BLOCK(pblk), .NEG_DRIVE_BLOCK(nblk),
    .TORQUE_LIMIT(tq));
  bes_motor_model u_motor (.CLK_SYS(clk), .MOTOR_POWER(pwr), .COMMAND_MASK(msk),
    .STOP_ACTIVE(stp), .STEP(st), .SPEED(spd));
  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One object access; read data is taken a cycle after the read edge.
  task automatic od(input logic [15:0] i, d, input logic w);
    @(posedge clk);
    idx <= i;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : od
  // Level of one watched output, picked by selector.
  function automatic logic seen(input int w);
    case (w)
      out_msk: return msk;
      out_stp: return stp;
      default: return pwr;
    endcase
  endfunction : seen
  // Bounded wait for a level; running out counts as a failure.
  task automatic wt(input int w, input logic v, output int c);
    c = 0;
    while (seen(w) !== v && c < 2000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 2000)
    begin
      errors++;
      stop_test();
    end
  endtask : wt
  // Set one control input at the next edge, then let two edges land.
  // A selector is used because a by-reference argument cannot take a non-blocking write.
  task automatic put(input int w, input logic v);
    @(posedge clk);
    case (w)
      in_en:   en <= v;
      in_alm:  alm <= v;
      in_qs:   qs <= v;
      in_hom:  hom <= v;
      in_hb:   hb <= v;
      in_pti:  pti <= v;
      default: nti <= v;
    endcase
    repeat (2) @(posedge clk);
    #1;
  endtask : put
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset", {eng, msk, pwr}, 3'h6);
    foreach (rows[k])
    begin
      if (rows[k].w)
        od(rows[k].i, rows[k].d, 1'b1);
      od(rows[k].i, 16'h0000, 1'b0);
      chk("object", rdat, rows[k].e);
    end
    // Power up, release delay of 2 ms, then a speed-ended stop.
    put(in_en, 1'b1);
    chk("release", {pwr, rel, msk}, 3'h7);
    wt(out_msk, 1'b0, n);
    chk("release time", n >= 17 && n <= 32, 1);
    put(in_en, 1'b0);
    // Braking setting 0x10 lies below the 0x20 maximum, so the smaller one must win.
    chk("braking cap", {stp, tq}, 17'h10010);
    wt(out_stp, 1'b0, n);
    chk("brake set", {pwr, rel, tq}, 18'h20020);
    wt(out_pwr, 1'b0, n);
    chk("off time", n >= 17 && n <= 32, 1);
    // A load that will not slow ends the stop on the 3 ms limit.
    st <= 16'h0000;
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    put(in_en, 1'b0);
    wt(out_stp, 1'b0, n);
    chk("decel limit", n >= 25 && n <= 42, 1);
    wt(out_pwr, 1'b0, n);
    st <= 16'h0100;
    // Alarm with stop disabled, then enabled.
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    put(in_alm, 1'b1);
    chk("no stop", {stp, ealm}, 2'h0);
    put(in_alm, 1'b0);
    od(16'h2443, 16'h0000, 1'b1);
    put(in_alm, 1'b1);
    chk("estop", {stp, ealm}, 2'h3);
    put(in_alm, 1'b0);
    put(in_en, 1'b0);
    wt(out_pwr, 1'b0, n);
    // Directional inhibit blocks one side and stops the drive.
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    put(in_pti, 1'b1);
    chk("block", {pblk, nblk, stp}, 3'h5);
    put(in_pti, 1'b0);
    put(in_en, 1'b0);
    wt(out_pwr, 1'b0, n);
    // Single-sided inhibit raises the travel alarm.
    od(16'h2504, 16'h0002, 1'b1);
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    put(in_nti, 1'b1);
    chk("travel alarm", {talm, stp}, 2'h3);
    put(in_nti, 1'b0);
    put(in_en, 1'b0);
    wt(out_pwr, 1'b0, n);
    // Ignored inputs, homing with the option bit, then a quick stop.
    od(16'h2504, 16'h0001, 1'b1);
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    put(in_pti, 1'b1);
    chk("ignored", {pblk, stp}, 2'h0);
    put(in_pti, 1'b0);
    od(16'h2504, 16'h0000, 1'b1);
    put(in_hb, 1'b1);
    put(in_hom, 1'b1);
    put(in_pti, 1'b1);
    chk("homing", {pblk, stp}, 2'h0);
    put(in_pti, 1'b0);
    put(in_qs, 1'b1);
    chk("quick stop", {stp, ealm}, 2'h2);
    put(in_en, 1'b0);
    wt(out_pwr, 1'b0, n);
    // Reset in mid-run drops the drive and restores the register defaults.
    put(in_qs, 1'b0);
    put(in_en, 1'b1);
    wt(out_msk, 1'b0, n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("mid reset", {eng, msk, pwr, stp, tq}, 20'hc0000);
    od(16'h2437, 16'h0000, 1'b0);
    chk("reset delay", rdat, 16'h0064);
    stop_test();
  end
endmodule : brake_estop_sequencer_tb
